// [flash_seq_params.svh]
// Constants for the flash page buffer erase-program sequencer
// Overview of operation
// - Reading command/status address returns flags; writing it issues a command byte.
// - Any command byte write clears all status flags, except bits set by a same-cycle event.
// - Page buffer holds 64 bytes, each with its own update flag.
// - Command 00H clears all buffer bytes and all update flags.
// - Data port write stores byte at low address [5:0] and sets its flag.
// - Each data write increments low address [5:0], wrapping; bits [7:6] kept.
// - Target page is high address register joined with low address bits [7:6].
// - Cycle erases and programs only flagged bytes of the selected page.
// - Command 68H starts erase-program and stalls the CPU until done or aborted.
// - On leaving program-idle, status shows the outcome of that cycle.
// - Interrupt during a cycle aborts it and sets status bit 0.
// - A system reset that aborts a cycle also sets status bit 0.
// - Each cycle lasts 4 ms: 2 ms erase then 2 ms program.
// - Targeting a secured page sets security violation, status bit 1.
// - High-voltage generator fault sets status bit 2.
// - Interrupt or brown-out in a cycle, or detector off at start, sets bit 3.
// - Non-secured code bytes stay readable by the code-read instruction.
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH

// ----------------------------------------------------------------------
// Register addresses on the special-function bus
// ----------------------------------------------------------------------
`define ADDR_CMD_STATUS 8'hE4
`define ADDR_PAGE_DATA  8'hE5
`define ADDR_ADDR_LOW   8'hE6
`define ADDR_ADDR_HIGH  8'hE7

// ----------------------------------------------------------------------
// Commands, flag bits and reset values
// ----------------------------------------------------------------------
`define CMD_LOAD        8'h00
`define CMD_ERASE_PROG  8'h68
`define FLAG_OI         0
`define FLAG_SV         1
`define FLAG_HVE        2
`define FLAG_HVA        3
`define STATUS_RESET    4'h0
`define ADDR_RESET      8'h00

// ----------------------------------------------------------------------
// Geometry and timing
// ----------------------------------------------------------------------
`define PAGE_BYTES      64
`define CLK_MHZ         250
`define PHASE_TIME_US   2000

`endif

// [flash_seq_pkg.sv]
// Types shared by the flash page buffer erase-program sequencer
package flash_seq_pkg;

  // Sequencer states: idle, erase phase, program phase
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROGRAM} seq_state_t;

  typedef logic [7:0] byte_t;
  typedef logic [5:0] page_idx_t;
  typedef logic [9:0] page_num_t;

endpackage

// [flash_seq_sync.sv]
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
module flash_seq_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule

// [flash_page_buffer.sv]
// Page buffer: 64 data bytes with one update flag each
`timescale 1ns/10ps
`include "flash_seq_params.svh"
module flash_page_buffer #(
  parameter int DEPTH = `PAGE_BYTES
) (
  input  wire logic                 clock_in,
  input  wire logic                 rstn_in,
  input  wire logic                 clear_in,
  input  wire logic                 wr_in,
  input  wire flash_seq_pkg::page_idx_t wr_idx_in,
  input  wire flash_seq_pkg::byte_t wr_data_in,
  input  wire flash_seq_pkg::page_idx_t rd_idx_in,
  output flash_seq_pkg::byte_t      rd_data_out,
  output logic [DEPTH-1:0]          flags_out
);

  flash_seq_pkg::byte_t mem_q [DEPTH];

  // Byte storage; clear wipes every location
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= 8'h00;
    end else if (clear_in) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= 8'h00;
    end else if (wr_in) begin
      mem_q[wr_idx_in] <= wr_data_in;
    end
  end

  // Update flags mark loaded locations
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags_out <= '0;
    end else if (clear_in) begin
      flags_out <= '0;
    end else if (wr_in) begin
      flags_out[wr_idx_in] <= 1'b1;
    end
  end

  // Registered read port toward the array
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= mem_q[rd_idx_in];
    end
  end

endmodule

// [flash_seq.sv]
// Flash erase-program sequencer with page buffer and SFR access
`timescale 1ns/10ps
`include "flash_seq_params.svh"
module flash_seq #(
  parameter int PHASE_CYCLES = `PHASE_TIME_US * `CLK_MHZ,
  parameter int CNT_W        = 20
) (
  input  wire logic                 clock_in,
  input  wire logic                 rstn_in,
  input  wire logic                 sys_reset_in,
  input  wire logic [7:0]           sfr_addr_in,
  input  wire logic                 sfr_wr_in,
  input  wire logic                 sfr_rd_in,
  input  wire logic [7:0]           sfr_wdata_in,
  output logic      [7:0]           sfr_rdata_out,
  input  wire logic                 irq_pending_in,
  input  wire logic                 bod_enable_in,
  input  wire logic                 brownout_in,
  input  wire logic                 hv_fault_in,
  input  wire logic                 page_secured_in,
  output logic                      cpu_stall_out,
  output logic                      flash_erase_out,
  output logic                      flash_prog_out,
  output flash_seq_pkg::page_num_t  flash_page_out,
  output logic [`PAGE_BYTES-1:0]    flash_mask_out,
  input  wire flash_seq_pkg::page_idx_t flash_rd_idx_in,
  output flash_seq_pkg::byte_t      flash_rd_data_out
);

  // --------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------
  logic [1:0] rst_pipe_q;
  logic       rstn;

  // Asynchronous assert, two-flop synchronous release
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rstn = rst_pipe_q[1];

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic brownout_s;
  logic hv_fault_s;

  flash_seq_sync #(.WIDTH(2)) pin_sync (
    .clock_in (clock_in),
    .rstn_in  (rstn),
    .d_in     ({brownout_in, hv_fault_in}),
    .q_out    ({brownout_s, hv_fault_s})
  );

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  flash_seq_pkg::seq_state_t state_q;
  logic busy;
  logic wr_cmd;
  logic wr_data;
  logic wr_low;
  logic wr_high;
  logic cmd_load;
  logic cmd_ep;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // Register writes; buffer and address writes ignored while busy
  assign busy     = (state_q != flash_seq_pkg::ST_IDLE);
  assign wr_cmd   = sfr_wr_in & hit(sfr_addr_in, `ADDR_CMD_STATUS);
  assign wr_data  = sfr_wr_in & hit(sfr_addr_in, `ADDR_PAGE_DATA) & ~busy;
  assign wr_low   = sfr_wr_in & hit(sfr_addr_in, `ADDR_ADDR_LOW) & ~busy;
  assign wr_high  = sfr_wr_in & hit(sfr_addr_in, `ADDR_ADDR_HIGH) & ~busy;
  assign cmd_load = wr_cmd & ~busy & (sfr_wdata_in == `CMD_LOAD);
  assign cmd_ep   = wr_cmd & ~busy & (sfr_wdata_in == `CMD_ERASE_PROG);

  // --------------------------------------------------------------------
  // Address registers
  // --------------------------------------------------------------------
  logic [7:0] addr_low_q;
  logic [7:0] addr_high_q;

  // Low address: written directly or stepped by each data write
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      addr_low_q <= `ADDR_RESET;
    end else if (sys_reset_in) begin
      addr_low_q <= `ADDR_RESET;
    end else if (wr_low) begin
      addr_low_q <= sfr_wdata_in;
    end else if (wr_data) begin
      addr_low_q <= {addr_low_q[7:6], 6'(addr_low_q[5:0] + 6'h01)};
    end
  end

  // High address register
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      addr_high_q <= `ADDR_RESET;
    end else if (sys_reset_in) begin
      addr_high_q <= `ADDR_RESET;
    end else if (wr_high) begin
      addr_high_q <= sfr_wdata_in;
    end
  end

  // Page selection drives the array address
  assign flash_page_out = {addr_high_q, addr_low_q[7:6]};

  // --------------------------------------------------------------------
  // Page buffer
  // --------------------------------------------------------------------
  logic [`PAGE_BYTES-1:0] flags;

  flash_page_buffer #(.DEPTH(`PAGE_BYTES)) page_buf (
    .clock_in    (clock_in),
    .rstn_in     (rstn),
    .clear_in    (cmd_load | sys_reset_in),
    .wr_in       (wr_data & ~sys_reset_in),
    .wr_idx_in   (addr_low_q[5:0]),
    .wr_data_in  (sfr_wdata_in),
    .rd_idx_in   (flash_rd_idx_in),
    .rd_data_out (flash_rd_data_out),
    .flags_out   (flags)
  );

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  logic [CNT_W-1:0] cnt_q;
  logic             phase_done;
  logic             start_ok;
  logic             abort;
  logic [3:0]       set_bits;
  logic [3:0]       status_q;

  // A start is refused on a secured page or with the detector off
  assign start_ok   = cmd_ep & ~page_secured_in & bod_enable_in;
  assign phase_done = (cnt_q == CNT_W'(PHASE_CYCLES - 1));
  assign abort      = busy & (irq_pending_in | brownout_s | hv_fault_s);

  // Erase phase then program phase, each a fixed length
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      state_q <= flash_seq_pkg::ST_IDLE;
    end else if (sys_reset_in || abort) begin
      state_q <= flash_seq_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        flash_seq_pkg::ST_IDLE: begin
          if (start_ok) state_q <= flash_seq_pkg::ST_ERASE;
        end
        flash_seq_pkg::ST_ERASE: begin
          if (phase_done) state_q <= flash_seq_pkg::ST_PROGRAM;
        end
        flash_seq_pkg::ST_PROGRAM: begin
          if (phase_done) state_q <= flash_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Phase timer restarts at each phase boundary
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (!busy || phase_done || abort || sys_reset_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= CNT_W'(cnt_q + 1'b1);
    end
  end

  // Snapshot of flagged bytes for the whole cycle
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      flash_mask_out <= '0;
    end else if (start_ok && !sys_reset_in) begin
      flash_mask_out <= flags;
    end else if (!busy || abort || sys_reset_in) begin
      flash_mask_out <= '0;
    end
  end

  // Array strobes; the array is free for code reads otherwise
  assign flash_erase_out = (state_q == flash_seq_pkg::ST_ERASE);
  assign flash_prog_out  = (state_q == flash_seq_pkg::ST_PROGRAM);
  assign cpu_stall_out   = busy;

  // --------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------
  // Event set bits
  always_comb begin
    set_bits = 4'h0;
    set_bits[`FLAG_OI]  = busy & (irq_pending_in | sys_reset_in);
    set_bits[`FLAG_SV]  = cmd_ep & page_secured_in;
    set_bits[`FLAG_HVE] = busy & hv_fault_s;
    set_bits[`FLAG_HVA] = (busy & (irq_pending_in | brownout_s))
                        | (cmd_ep & ~bod_enable_in);
  end

  // Command write clears, but a same-cycle event wins
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      status_q <= `STATUS_RESET;
    end else if (wr_cmd) begin
      status_q <= set_bits;
    end else begin
      status_q <= status_q | set_bits;
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  // Registered read answer one cycle after the strobe
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_rd_in) begin
      if (hit(sfr_addr_in, `ADDR_CMD_STATUS)) begin
        sfr_rdata_out <= {4'h0, status_q};
      end else if (hit(sfr_addr_in, `ADDR_ADDR_LOW)) begin
        sfr_rdata_out <= addr_low_q;
      end else if (hit(sfr_addr_in, `ADDR_ADDR_HIGH)) begin
        sfr_rdata_out <= addr_high_q;
      end else begin
        sfr_rdata_out <= 8'h00;
      end
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic [CNT_W:0] run_len_q;

  // Length of the current stall, for the cycle-length check
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      run_len_q <= '0;
    end else if (!busy) begin
      run_len_q <= '0;
    end else begin
      run_len_q <= (CNT_W+1)'(run_len_q + 1'b1);
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn);

  cmd_clears_a: assert property (
    wr_cmd && !busy && !cmd_ep |=> status_q == 4'h0)
    else $error("status not cleared by command write");

  load_clears_a: assert property (
    cmd_load && !sys_reset_in |=> flags == '0)
    else $error("load command left flags set");

  data_flag_a: assert property (
    wr_data && !sys_reset_in |=> flags[$past(addr_low_q[5:0])])
    else $error("data write did not set update flag");

  addr_step_a: assert property (
    wr_data && !sys_reset_in |=>
      addr_low_q[5:0] == 6'($past(addr_low_q[5:0]) + 6'h01)
      && addr_low_q[7:6] == $past(addr_low_q[7:6]))
    else $error("low address did not step correctly");

  start_stall_a: assert property (
    start_ok && !sys_reset_in |=> cpu_stall_out && flash_erase_out)
    else $error("erase-program start did not stall");

  cycle_len_a: assert property (
    busy && !abort && !sys_reset_in && flash_prog_out && phase_done
      |-> run_len_q == (CNT_W+1)'(2 * PHASE_CYCLES - 1))
    else $error("erase-program cycle length wrong");

  irq_abort_a: assert property (
    busy && irq_pending_in |=> !cpu_stall_out
      && status_q[`FLAG_OI] && status_q[`FLAG_HVA])
    else $error("interrupt did not abort with flags");

  secure_refuse_a: assert property (
    cmd_ep && page_secured_in |=> !cpu_stall_out && status_q[`FLAG_SV])
    else $error("secured page start not refused");

  hv_error_a: assert property (
    busy && hv_fault_s |=> status_q[`FLAG_HVE] && !cpu_stall_out)
    else $error("voltage fault not flagged");

  other_cmd_a: assert property (
    wr_cmd && !cmd_load && !cmd_ep && !sys_reset_in |=>
      $stable(flags) && $stable(flash_page_out))
    else $error("other command disturbed buffer or page");

  // Snapshot, read-back, sequencing, outcome and refusal checks
  mask_snap_a: assert property (
    start_ok && !sys_reset_in |=> flash_mask_out == $past(flags))
    else $error("mask not taken from update flags at start");

  status_read_a: assert property (
    sfr_rd_in && sfr_addr_in == `ADDR_CMD_STATUS |=>
      sfr_rdata_out == {4'h0, $past(status_q)})
    else $error("status read returned wrong flags");

  reset_abort_a: assert property (
    busy && sys_reset_in |=> !cpu_stall_out
      && status_q[`FLAG_OI] && flags == '0)
    else $error("reset did not abort with flag");

  bod_refuse_a: assert property (
    cmd_ep && !bod_enable_in |=> !cpu_stall_out && status_q[`FLAG_HVA])
    else $error("start with detector off not refused");

  brownout_abort_a: assert property (
    busy && brownout_s |=> !cpu_stall_out && status_q[`FLAG_HVA])
    else $error("brown-out did not abort with flag");

  prog_follows_a: assert property (
    flash_erase_out && phase_done && !abort && !sys_reset_in
      |=> flash_prog_out)
    else $error("program phase did not follow erase");

  cycle_end_a: assert property (
    flash_prog_out && phase_done && !abort && !sys_reset_in
      |=> !cpu_stall_out)
    else $error("program-idle not left after cycle");

  // Main scenarios reached by the bench
  hv_abort_c: cover property (busy && hv_fault_s);
  full_cycle_c: cover property (
    flash_prog_out && phase_done && !abort ##1 !cpu_stall_out);
  irq_abort_c: cover property (busy && irq_pending_in);
  secured_c: cover property (cmd_ep && page_secured_in);
  wrap_c: cover property (wr_data && addr_low_q[5:0] == 6'h3F);

endmodule

// [cpu_model.sv]
// Behavioural CPU core driving the special-function register bus
`timescale 1ns/10ps
module cpu_model (
  input  wire logic       clock_in,
  input  wire logic       stall_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic      [7:0] wdata_out,
  output logic            irq_out
);
  // ------------------------------------------------------------------
  // Idle bus levels
  // ------------------------------------------------------------------
  initial begin
    addr_out  = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    wdata_out = 8'h00;
    irq_out   = 1'b0;
  end

  // ------------------------------------------------------------------
  // One access; a held CPU issues nothing until program-idle ends or 200 stalled cycles pass
  // ------------------------------------------------------------------
  task automatic access(input logic is_wr, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clock_in);
    #1;
    while (stall_in === 1'b1 && n < 200) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    addr_out  = a;
    wdata_out = d;
    wr_out    = is_wr;
    rd_out    = !is_wr;
    @(posedge clock_in);
    #1;
    q         = rdata_in;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    addr_out  = ~a;  // Released lines do not keep the old value
    wdata_out = ~d;
  endtask

  // One-cycle interrupt request
  task automatic pulse_irq();
    @(posedge clock_in);
    #1;
    irq_out = 1'b1;
    @(posedge clock_in);
    #1;
    irq_out = 1'b0;
  endtask
endmodule

// [flash_page_buffer_erase_program_test.sv]
// Self-checking testbench for the flash erase-program sequencer
`timescale 1ns/10ps
`include "flash_seq_params.svh"
module flash_page_buffer_erase_program_test;
  localparam int P = 20;
  logic clock_in, rstn_in, sys_reset_in, sfr_wr_in, sfr_rd_in;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, q;
  logic irq_pending_in, bod_enable_in, brownout_in, hv_fault_in;
  logic page_secured_in, cpu_stall_out, flash_erase_out, flash_prog_out;
  flash_seq_pkg::page_num_t flash_page_out;
  logic [`PAGE_BYTES-1:0] flash_mask_out;
  flash_seq_pkg::page_idx_t flash_rd_idx_in;
  flash_seq_pkg::byte_t flash_rd_data_out;
  int err_count, n_compared, cycles, e, p;

  // ------------------------------------------------------------------
  // Design, CPU model, clock
  // ------------------------------------------------------------------
  flash_seq #(.PHASE_CYCLES(P)) DUT (
    .clock_in          (clock_in),
    .rstn_in           (rstn_in),
    .sys_reset_in      (sys_reset_in),
    .sfr_addr_in       (sfr_addr_in),
    .sfr_wr_in         (sfr_wr_in),
    .sfr_rd_in         (sfr_rd_in),
    .sfr_wdata_in      (sfr_wdata_in),
    .sfr_rdata_out     (sfr_rdata_out),
    .irq_pending_in    (irq_pending_in),
    .bod_enable_in     (bod_enable_in),
    .brownout_in       (brownout_in),
    .hv_fault_in       (hv_fault_in),
    .page_secured_in   (page_secured_in),
    .cpu_stall_out     (cpu_stall_out),
    .flash_erase_out   (flash_erase_out),
    .flash_prog_out    (flash_prog_out),
    .flash_page_out    (flash_page_out),
    .flash_mask_out    (flash_mask_out),
    .flash_rd_idx_in   (flash_rd_idx_in),
    .flash_rd_data_out (flash_rd_data_out)
  );
  cpu_model cpu (.clock_in(clock_in), .stall_in(cpu_stall_out),
    .rdata_in(sfr_rdata_out), .addr_out(sfr_addr_in), .wr_out(sfr_wr_in),
    .rd_out(sfr_rd_in), .wdata_out(sfr_wdata_in), .irq_out(irq_pending_in));
  initial clock_in = 1'b0;
  always #2 clock_in = ~clock_in;

  // Hang guard
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      results();
    end
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] x,
                     input logic [63:0] g);
    n_compared++;
    if (g !== x) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu.access(1'b1, a, d, q);
  endtask
  task automatic st(input logic [7:0] x);
    cpu.access(1'b0, `ADDR_CMD_STATUS, 8'h00, q);
    chk("status", {56'h0, x}, {56'h0, q});
  endtask
  task automatic bufchk(input logic [5:0] i, input logic [7:0] x);
    @(posedge clock_in);
    #1;
    flash_rd_idx_in = i;
    @(posedge clock_in);
    #1;
    chk("buffer byte", {56'h0, x}, {56'h0, flash_rd_data_out});
  endtask
  // Count erase and program cycles until the stall ends
  task automatic wait_idle();
    e = 0;
    p = 0;
    while (cpu_stall_out === 1'b1 && e + p < 200) begin
      if (flash_erase_out === 1'b1) e++;
      if (flash_prog_out === 1'b1) p++;
      @(posedge clock_in);
      #1;
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    rstn_in = 1'b0;
    sys_reset_in = 1'b0;
    bod_enable_in = 1'b1;
    brownout_in = 1'b0;
    hv_fault_in = 1'b0;
    page_secured_in = 1'b0;
    flash_rd_idx_in = 6'h00;
    repeat (3) @(posedge clock_in);
    #1;
    rstn_in = 1'b1;
    repeat (3) @(posedge clock_in);
    st(8'h00);
    cpu.access(1'b0, 8'hE0, 8'h00, q);
    chk("unmapped read", 64'h0, {56'h0, q});
    $display("test reset done");
    // Load four bytes across the wrap point
    wr(`ADDR_CMD_STATUS, `CMD_LOAD);
    wr(`ADDR_ADDR_LOW, 8'h7E);
    wr(`ADDR_ADDR_HIGH, 8'h12);
    wr(`ADDR_PAGE_DATA, 8'hAA);
    wr(`ADDR_PAGE_DATA, 8'hBB);
    wr(`ADDR_PAGE_DATA, 8'hCC);
    wr(`ADDR_PAGE_DATA, 8'hDD);
    bufchk(6'h3E, 8'hAA);
    bufchk(6'h3F, 8'hBB);
    bufchk(6'h00, 8'hCC);
    bufchk(6'h01, 8'hDD);
    chk("page", 64'h049, {54'h0, flash_page_out});
    $display("test load done");
    // Full erase-program cycle
    wr(`ADDR_CMD_STATUS, `CMD_ERASE_PROG);
    chk("stall", 64'h1, {63'h0, cpu_stall_out});
    chk("mask", 64'hC000_0000_0000_0003, flash_mask_out);
    wait_idle();
    chk("erase cycles", 64'(P), 64'(e));
    chk("program cycles", 64'(P), 64'(p));
    st(8'h00);
    chk("mask idle", 64'h0, flash_mask_out);
    $display("test erase program done");
    // Clear, reload one byte, then abort by interrupt
    wr(`ADDR_CMD_STATUS, `CMD_LOAD);
    bufchk(6'h3E, 8'h00);
    wr(`ADDR_PAGE_DATA, 8'h11);
    wr(`ADDR_CMD_STATUS, `CMD_ERASE_PROG);
    repeat (5) @(posedge clock_in);
    cpu.pulse_irq();
    chk("stall after irq", 64'h0, {63'h0, cpu_stall_out});
    st(8'h09);
    wr(`ADDR_CMD_STATUS, 8'h55);
    st(8'h00);
    chk("page kept", 64'h049, {54'h0, flash_page_out});
    bufchk(6'h02, 8'h11);
    wr(`ADDR_CMD_STATUS, `CMD_LOAD);
    $display("test interrupt abort done");
    // Refused starts
    page_secured_in = 1'b1;
    wr(`ADDR_CMD_STATUS, `CMD_ERASE_PROG);
    chk("no start secured", 64'h0, {63'h0, cpu_stall_out});
    st(8'h02);
    page_secured_in = 1'b0;
    bod_enable_in = 1'b0;
    wr(`ADDR_CMD_STATUS, `CMD_ERASE_PROG);
    st(8'h08);
    bod_enable_in = 1'b1;
    $display("test refused start done");
    // High-voltage fault and brown-out aborts
    wr(`ADDR_CMD_STATUS, `CMD_ERASE_PROG);
    repeat (3) @(posedge clock_in);
    #1;
    hv_fault_in = 1'b1;
    wait_idle();
    hv_fault_in = 1'b0;
    chk("hv abort cycles", 64'd3, 64'(e + p));
    st(8'h04);
    wr(`ADDR_CMD_STATUS, `CMD_ERASE_PROG);
    repeat (3) @(posedge clock_in);
    #1;
    brownout_in = 1'b1;
    wait_idle();
    brownout_in = 1'b0;
    st(8'h08);
    $display("test fault abort done");
    // System reset in mid-cycle
    wr(`ADDR_CMD_STATUS, `CMD_ERASE_PROG);
    repeat (4) @(posedge clock_in);
    #1;
    sys_reset_in = 1'b1;
    @(posedge clock_in);
    #1;
    sys_reset_in = 1'b0;
    wait_idle();
    st(8'h01);
    chk("page cleared", 64'h0, {54'h0, flash_page_out});
    $display("test reset abort done");
    results();
  end
endmodule
